// file: include/ufc_cfg.svh
// Purpose: constants of the uart flow-control block
// Assumes: apb byte addresses, 32-bit aligned words
// Notes:   definitions only
`ifndef UFC_CFG_SVH
`define UFC_CFG_SVH

`define UFC_AW            8
`define UFC_OFF_EFR       8'h00
`define UFC_OFF_FCR       8'h04
`define UFC_OFF_AFR       8'h08
`define UFC_OFF_IER       8'h0C
`define UFC_OFF_ISR       8'h10
`define UFC_OFF_MSR       8'h14
`define UFC_OFF_FSR       8'h18
`define UFC_OFF_FUR       8'h1C
`define UFC_OFF_FLR       8'h20
`define UFC_OFF_CHR       8'h24

`define UFC_EFR_CTS       7
`define UFC_IER_CTS       7
`define UFC_FCR_EN        0
`define UFC_AFR_DEEP      0
`define UFC_FSR_RXSTOP    0
`define UFC_FSR_CTS       1
`define UFC_FSR_TXSTOP    4
`define UFC_MSR_DCTS      0
`define UFC_MSR_CTS       4

`define UFC_RST_BYTE      8'h00
`define UFC_RST_CHR       32'h1313_1111
`define UFC_ISR_NONE      6'h01
`define UFC_ISR_CTS       6'h20

`define UFC_UP0           9'h008
`define UFC_UP1           9'h010
`define UFC_UP2           9'h038
`define UFC_UP3           9'h03C
`define UFC_LO0           9'h000
`define UFC_LO1           9'h008
`define UFC_LO2           9'h010
`define UFC_LO3           9'h038

`endif

// file: include/ufc_pkg.sv
// Purpose: types shared by the uart flow-control block
// Assumes: constants live in ufc_cfg.svh
// Notes:   no import; use ufc_pkg::name
package ufc_pkg;

	typedef struct packed {
		logic       psel;
		logic       penable;
		logic       pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} ufc_apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} ufc_apb_rsp_t;

	typedef struct packed {
		logic       start;
		logic [7:0] data;
	} ufc_ser_cmd_t;

	typedef enum logic [2:0] {
		TS_IDLE   = 3'b001,
		TS_LAUNCH = 3'b010,
		TS_BUSY   = 3'b100
	} ufc_tx_state_t;

endpackage

// file: rtl/ufc_sync.sv
// Purpose: two-flop synchroniser for pin levels
// Assumes: inputs are quasi-static levels
// Notes:   first stage feeds only the second
`timescale 1ns/10ps
module ufc_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= '1;
			q      <= '1;
		end else begin
			meta_q <= d;
			q      <= meta_q;
		end
	end
endmodule // ufc_sync

// file: rtl/ufc_rx_match.sv
// Purpose: detect resume/stop characters from the far end
// Assumes: rx_valid is a one-cycle pulse per received char
// Notes:   chars = {stop2, stop1, resume2, resume1}
`timescale 1ns/10ps
module ufc_rx_match (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [1:0]  mode,
	input  wire logic [31:0] chars,
	input  wire logic        rx_valid,
	input  wire logic [7:0]  rx_char,
	output logic             rx_stop
);
	logic on1, on2, off1, off2;
	logic seen_on_q, seen_off_q;

	assign on1  = rx_char == chars[7:0];
	assign on2  = rx_char == chars[15:8];
	assign off1 = rx_char == chars[23:16];
	assign off2 = rx_char == chars[31:24];

	// resume is tested first: equal codes count as resume
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_stop <= 1'b0;
		end else if (mode == 2'b00) begin
			rx_stop <= 1'b0;
		end else if (rx_valid) begin
			case (mode)
			2'b10: begin
				if (on1)
					rx_stop <= 1'b0;
				else if (off1)
					rx_stop <= 1'b1;
			end
			2'b01: begin
				if (on2)
					rx_stop <= 1'b0;
				else if (off2)
					rx_stop <= 1'b1;
			end
			default: begin
				if (seen_on_q && on2)
					rx_stop <= 1'b0;
				else if (seen_off_q && off2)
					rx_stop <= 1'b1;
			end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			seen_on_q  <= 1'b0;
			seen_off_q <= 1'b0;
		end else if (mode != 2'b11) begin
			seen_on_q  <= 1'b0;
			seen_off_q <= 1'b0;
		end else if (rx_valid) begin
			seen_on_q  <= on1;
			seen_off_q <= off1 && !on1;
		end
	end

	a_rx_stop_one: assert property (
		@(posedge pclk) disable iff (!presetn)
		rx_valid && mode == 2'b10 && off1 && !on1 |=> rx_stop)
		else $error("stop char did not halt transmit");

	a_rx_resume_two: assert property (
		@(posedge pclk) disable iff (!presetn)
		rx_valid && mode == 2'b11 && seen_on_q && on2
		|=> !rx_stop)
		else $error("resume pair did not release transmit");
endmodule // ufc_rx_match

// file: rtl/ufc_flow_top.sv
// Purpose: flow control of one uart channel behind an apb slave
// Assumes: first-word-fall-through tx fifo; serializer raises
//          ser_busy the cycle after ser_cmd.start
// Notes:   cts_n_in is a pin and is synchronised
//
// Implementation choices: the APB slave port and the address map.
`timescale 1ns/10ps
`include "ufc_cfg.svh"
module ufc_flow_top #(
	parameter int FILL_W = 9
) (
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	input  wire ufc_pkg::ufc_apb_req_t apb_req,
	output ufc_pkg::ufc_apb_rsp_t     apb_rsp,
	input  wire logic                 cts_n_in,
	input  wire logic [FILL_W-1:0]    rx_fill_count,
	input  wire logic                 rx_char_valid,
	input  wire logic [7:0]           rx_char,
	input  wire logic                 txf_valid,
	input  wire logic [7:0]           txf_data,
	output logic                      txf_pop,
	input  wire logic                 ser_busy,
	output ufc_pkg::ufc_ser_cmd_t     ser_cmd,
	output logic                      irq
);
	if (FILL_W < 9) begin : g_chk
		$error("FILL_W must hold a count of 256");
	end

	logic [7:0]  efr_q, fcr_q, afr_q, ier_q, fur_q, flr_q;
	logic [31:0] chr_q;
	logic        cts_s, cts_last_q, cts_rise, cts_int_q;
	logic        rx_stop, tx_stop_q, pend_q, pend_stop_q, pend_idx_q;
	logic        deep, txsw_en, cts_block, take_flow, take_data;
	logic        wr_en, rd_done, setup, hit;
	logic        launch_data_q;
	logic [8:0]  upper, lower;
	logic [FILL_W-1:0] fill;
	logic [7:0]  flow_char;
	logic [31:0] rd_val;
	ufc_pkg::ufc_tx_state_t tx_st_q;

	function automatic logic [8:0] thr_lut(input logic [1:0] code,
		input logic up);
		case ({up, code})
		3'b100:  thr_lut = `UFC_UP0;
		3'b101:  thr_lut = `UFC_UP1;
		3'b110:  thr_lut = `UFC_UP2;
		3'b111:  thr_lut = `UFC_UP3;
		3'b000:  thr_lut = `UFC_LO0;
		3'b001:  thr_lut = `UFC_LO1;
		3'b010:  thr_lut = `UFC_LO2;
		default: thr_lut = `UFC_LO3;
		endcase
	endfunction

	// stop flag or resume flag, first or second of the pair
	function automatic logic [7:0] pick_char(input logic [31:0] c,
		input logic stop, input logic second);
		case ({stop, second})
		2'b00:   pick_char = c[7:0];
		2'b01:   pick_char = c[15:8];
		2'b10:   pick_char = c[23:16];
		default: pick_char = c[31:24];
		endcase
	endfunction

	ufc_sync #(.W(1)) u_cts_sync (
		.clk   (pclk),
		.rst_n (presetn),
		.d     (cts_n_in),
		.q     (cts_s)
	);

	ufc_rx_match u_match (
		.pclk     (pclk),
		.presetn  (presetn),
		.mode     (efr_q[1:0]),
		.chars    (chr_q),
		.rx_valid (rx_char_valid),
		.rx_char  (rx_char),
		.rx_stop  (rx_stop)
	);

	assign fill      = rx_fill_count;
	assign deep      = fcr_q[`UFC_FCR_EN] & afr_q[`UFC_AFR_DEEP];
	assign upper     = deep ? {1'b0, fur_q} : thr_lut(fcr_q[7:6], 1'b1);
	assign lower     = deep ? {1'b0, flr_q} : thr_lut(fcr_q[5:4], 1'b0);
	assign txsw_en   = |efr_q[3:2];
	assign cts_block = efr_q[`UFC_EFR_CTS] & cts_s;
	assign cts_rise  = cts_s & ~cts_last_q;
	assign flow_char = pick_char(chr_q, pend_stop_q,
		efr_q[3:2] == 2'b01 || pend_idx_q);
	assign take_flow = tx_st_q == ufc_pkg::TS_IDLE && pend_q;
	assign take_data = tx_st_q == ufc_pkg::TS_IDLE && !pend_q &&
		txf_valid && !cts_block && !rx_stop;

	// apb: registered answer, pready in the access cycle
	assign setup   = apb_req.psel & ~apb_req.penable;
	assign wr_en   = apb_req.psel & apb_req.penable & apb_rsp.pready &
		apb_req.pwrite;
	assign rd_done = apb_req.psel & apb_req.penable & apb_rsp.pready &
		~apb_req.pwrite;

	always_comb begin
		hit    = 1'b1;
		rd_val = 32'h0000_0000;
		case (apb_req.paddr)
		`UFC_OFF_EFR: rd_val[7:0] = efr_q;
		`UFC_OFF_FCR: rd_val[7:0] = fcr_q;
		`UFC_OFF_AFR: rd_val[7:0] = afr_q;
		`UFC_OFF_IER: rd_val[7:0] = ier_q;
		`UFC_OFF_ISR: rd_val[5:0] = cts_int_q ? `UFC_ISR_CTS
			: `UFC_ISR_NONE;
		`UFC_OFF_MSR: begin
			rd_val[`UFC_MSR_DCTS] = cts_int_q;
			rd_val[`UFC_MSR_CTS]  = ~cts_s;
		end
		`UFC_OFF_FSR: begin
			rd_val[`UFC_FSR_RXSTOP] = rx_stop;
			rd_val[`UFC_FSR_CTS]    = cts_block;
			rd_val[`UFC_FSR_TXSTOP] = txsw_en & tx_stop_q;
		end
		`UFC_OFF_FUR: rd_val[8:0] = upper;
		`UFC_OFF_FLR: rd_val[8:0] = lower;
		`UFC_OFF_CHR: rd_val = chr_q;
		default: hit = 1'b0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			apb_rsp <= '0;
		end else if (setup) begin
			apb_rsp.pready  <= 1'b1;
			apb_rsp.pslverr <= ~hit;
			apb_rsp.prdata  <= apb_req.pwrite ? 32'h0000_0000 : rd_val;
		end else begin
			apb_rsp <= '0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			efr_q <= `UFC_RST_BYTE;
			fcr_q <= `UFC_RST_BYTE;
			afr_q <= `UFC_RST_BYTE;
			ier_q <= `UFC_RST_BYTE;
			fur_q <= `UFC_RST_BYTE;
			flr_q <= `UFC_RST_BYTE;
			chr_q <= `UFC_RST_CHR;
		end else if (wr_en) begin
			case (apb_req.paddr)
			`UFC_OFF_EFR: efr_q <= apb_req.pwdata[7:0];
			`UFC_OFF_FCR: fcr_q <= apb_req.pwdata[7:0];
			`UFC_OFF_AFR: afr_q <= apb_req.pwdata[7:0];
			`UFC_OFF_IER: ier_q <= apb_req.pwdata[7:0];
			`UFC_OFF_FUR: if (deep) fur_q <= apb_req.pwdata[7:0];
			`UFC_OFF_FLR: if (deep) flr_q <= apb_req.pwdata[7:0];
			`UFC_OFF_CHR: chr_q <= apb_req.pwdata;
			default: ;
			endcase
		end
	end

	// cts_n_in rise interrupt, falls are ignored; a new rise beats the read clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cts_last_q <= 1'b1;
			cts_int_q  <= 1'b0;
			irq        <= 1'b0;
		end else begin
			cts_last_q <= cts_s;
			if (cts_rise && ier_q[`UFC_IER_CTS])
				cts_int_q <= 1'b1;
			else if (rd_done && apb_req.paddr == `UFC_OFF_MSR)
				cts_int_q <= 1'b0;
			irq <= cts_int_q;
		end
	end

	// transmit soft flow; a new event overrides a half-sent pair
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_stop_q   <= 1'b0;
			pend_q      <= 1'b0;
			pend_stop_q <= 1'b0;
			pend_idx_q  <= 1'b0;
		end else if (!txsw_en) begin
			tx_stop_q  <= 1'b0;
			pend_q     <= 1'b0;
			pend_idx_q <= 1'b0;
		end else if (!tx_stop_q && fill > FILL_W'(upper)) begin
			tx_stop_q   <= 1'b1;
			pend_q      <= 1'b1;
			pend_stop_q <= 1'b1;
			pend_idx_q  <= 1'b0;
		end else if (tx_stop_q && fill == FILL_W'(lower)) begin
			tx_stop_q   <= 1'b0;
			pend_q      <= 1'b1;
			pend_stop_q <= 1'b0;
			pend_idx_q  <= 1'b0;
		end else if (take_flow) begin
			if (efr_q[3:2] == 2'b11 && !pend_idx_q) begin
				pend_idx_q <= 1'b1;
			end else begin
				pend_q     <= 1'b0;
				pend_idx_q <= 1'b0;
			end
		end
	end

	// character launcher; waits for the serializer between chars
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_st_q       <= ufc_pkg::TS_IDLE;
			ser_cmd       <= '0;
			txf_pop       <= 1'b0;
			launch_data_q <= 1'b0;
		end else begin
			txf_pop       <= 1'b0;
			ser_cmd.start <= 1'b0;
			case (tx_st_q)
			ufc_pkg::TS_IDLE: begin
				if (take_flow) begin
					ser_cmd.start <= 1'b1;
					ser_cmd.data  <= flow_char;
					launch_data_q <= 1'b0;
					tx_st_q       <= ufc_pkg::TS_LAUNCH;
				end else if (take_data) begin
					ser_cmd.start <= 1'b1;
					ser_cmd.data  <= txf_data;
					txf_pop       <= 1'b1;
					launch_data_q <= 1'b1;
					tx_st_q       <= ufc_pkg::TS_LAUNCH;
				end
			end
			ufc_pkg::TS_LAUNCH: tx_st_q <= ufc_pkg::TS_BUSY;
			ufc_pkg::TS_BUSY: begin
				if (!ser_busy)
					tx_st_q <= ufc_pkg::TS_IDLE;
			end
			default: tx_st_q <= ufc_pkg::TS_IDLE;
			endcase
		end
	end

	a_cts_hold_data: assert property (
		@(posedge pclk) disable iff (!presetn)
		txf_pop |-> $past(!cts_block && !rx_stop))
		else $error("fifo data sent while held");

	a_cts_irq_set: assert property (
		@(posedge pclk) disable iff (!presetn)
		cts_rise && ier_q[7] |=> cts_int_q ##1 irq)
		else $error("cts rise did not raise interrupt");

	a_msr_rd_clear: assert property (
		@(posedge pclk) disable iff (!presetn)
		rd_done && apb_req.paddr == `UFC_OFF_MSR && !cts_rise
		|=> !cts_int_q)
		else $error("modem status read left interrupt");

	a_irq_cause_cts: assert property (
		@(posedge pclk) disable iff (!presetn)
		$rose(cts_int_q) |-> $past(cts_rise && ier_q[7]))
		else $error("interrupt without cts rise");

	a_sw_enable_quiet: assert property (
		@(posedge pclk) disable iff (!presetn)
		$rose(txsw_en) |-> !tx_stop_q && !pend_q)
		else $error("enable did not start in resume");

	a_stop_enter: assert property (
		@(posedge pclk) disable iff (!presetn)
		txsw_en && !tx_stop_q && fill > FILL_W'(upper)
		|=> tx_stop_q && pend_q && pend_stop_q)
		else $error("upper crossing did not stop");

	a_resume_wait: assert property (
		@(posedge pclk) disable iff (!presetn)
		txsw_en && tx_stop_q && fill != FILL_W'(lower) && $stable(efr_q)
		|=> tx_stop_q)
		else $error("resumed before lower threshold");

	a_upper_lut: assert property (
		@(posedge pclk) disable iff (!presetn)
		!deep && fcr_q[7:6] == 2'b11 |-> upper == 9'h03C)
		else $error("upper threshold code 3 wrong");

	a_lower_lut: assert property (
		@(posedge pclk) disable iff (!presetn)
		!deep && fcr_q[5:4] == 2'b01 |-> lower == 9'h008)
		else $error("lower threshold code 1 wrong");

	a_flow_first: assert property (
		@(posedge pclk) disable iff (!presetn)
		tx_st_q == ufc_pkg::TS_IDLE && pend_q
		|=> ser_cmd.start && !launch_data_q && !txf_pop)
		else $error("flow char not ahead of data");
endmodule // ufc_flow_top

// file: dv/ufc_far_end.sv
// Purpose: serializer and far-end receiver beside the flow block
// Assumes: one start pulse per char, busy from the next cycle
// Notes:   every launched char lands in got for the bench
`timescale 1ns/10ps
module ufc_far_end (
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	input  wire ufc_pkg::ufc_ser_cmd_t ser_cmd,
	input  wire logic                  slow,
	output logic                       ser_busy
);
	logic [3:0] left_q;
	logic [7:0] got[$];

	// slow mode stretches a char so queued work has to wait
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			left_q <= 4'h0;
			ser_busy <= 1'b0;
		end else if (ser_cmd.start) begin
			left_q <= slow ? 4'h9 : 4'h2;
			ser_busy <= 1'b1;
			got.push_back(ser_cmd.data);
		end else if (left_q != 4'h0) begin
			left_q <= left_q - 4'h1;
			ser_busy <= (left_q != 4'h1);
		end
	end
endmodule // ufc_far_end

// file: dv/ufc_flow_top_test.sv
// Purpose: self-checking bench of the uart flow-control block
// Assumes: apb answers are sampled on the rising edge
// Notes:   tx fifo is one entry, dropped on txf_pop
`timescale 1ns/10ps
`include "ufc_cfg.svh"
module ufc_flow_top_test;
	logic                  pclk;
	logic                  presetn;
	ufc_pkg::ufc_apb_req_t req;
	ufc_pkg::ufc_apb_rsp_t rsp;
	logic                  cts_n_in;
	logic [8:0]            fill;
	logic                  rx_v;
	logic [7:0]            rx_c;
	logic                  txf_valid;
	logic [7:0]            txf_data;
	logic                  txf_pop;
	logic                  ser_busy;
	ufc_pkg::ufc_ser_cmd_t ser_cmd;
	logic                  irq;
	logic                  slow;
	logic [31:0]           rdat;
	logic                  rerr;
	int                    errors;
	int                    total_checks;
	int                    cyc;
	logic [15:0] stop_t [3] = '{16'h3300, 16'h4400, 16'h3344};
	logic [15:0] res_t  [3] = '{16'h1100, 16'h2200, 16'h1122};
	int          n_t    [3] = '{1, 1, 2};
	logic [7:0]  ftx_t  [3] = '{8'h08, 8'h04, 8'h0C};
	logic [7:0]  frx_t  [3] = '{8'h02, 8'h01, 8'h03};
	logic [8:0]  up_t   [4] = '{9'h008, 9'h010, 9'h038, 9'h03C};
	logic [8:0]  lo_t   [4] = '{9'h000, 9'h008, 9'h010, 9'h038};

	ufc_flow_top #(.FILL_W(9)) ufc_flow_top_i (.pclk(pclk),
		.presetn(presetn), .apb_req(req), .apb_rsp(rsp),
		.cts_n_in(cts_n_in), .rx_fill_count(fill), .rx_char_valid(rx_v),
		.rx_char(rx_c), .txf_valid(txf_valid), .txf_data(txf_data),
		.txf_pop(txf_pop), .ser_busy(ser_busy), .ser_cmd(ser_cmd),
		.irq(irq));
	ufc_far_end ufc_far_end_i (.pclk(pclk), .presetn(presetn),
		.ser_cmd(ser_cmd), .slow(slow), .ser_busy(ser_busy));

	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	always @(posedge pclk) begin
		if (txf_pop)
			txf_valid <= 1'b0;
		cyc++;
		if (cyc == 6000) begin
			errors++;
			end_of_test();
		end
	end

	task automatic end_of_test;
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask

	// request held until pready is seen, released after that edge
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		req.psel <= 1'b1;
		req.penable <= 1'b0;
		req.pwrite <= w;
		req.paddr <= a;
		req.pwdata <= d;
		@(posedge pclk);
		req.penable <= 1'b1;
		// answer read at the edge, ahead of that edge's updates
		do
			@(posedge pclk);
		while (rsp.pready !== 1'b1);
		rdat = rsp.prdata;
		rerr = rsp.pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk($sformatf("reg %h", a), e, rdat);
	endtask

	task automatic chk_tx(input logic [15:0] e, input int n);
		repeat (40) @(posedge pclk);
		chk("tx count", n, ufc_far_end_i.got.size());
		if (n > 0)
			chk("tx first", e[15:8], ufc_far_end_i.got[0]);
		if (n > 1)
			chk("tx second", e[7:0], ufc_far_end_i.got[1]);
		ufc_far_end_i.got.delete();
	endtask

	task automatic rx_seq(input logic [15:0] s, input int n);
		for (int k = 0; k < n; k++) begin
			rx_c <= k == 0 ? s[15:8] : s[7:0];
			rx_v <= 1'b1;
			@(posedge pclk);
			rx_v <= 1'b0;
			@(posedge pclk);
		end
	endtask

	task automatic load(input logic [7:0] d);
		txf_data <= d;
		txf_valid <= 1'b1;
	endtask

	initial begin
		presetn = 1'b0;
		req = '0;
		cts_n_in = 1'b0;
		fill = 9'h000;
		rx_v = 1'b0;
		rx_c = 8'h00;
		txf_valid = 1'b0;
		txf_data = 8'h00;
		slow = 1'b0;
		errors = 0;
		total_checks = 0;
		cyc = 0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(`UFC_OFF_EFR, 32'h0);
		rd(`UFC_OFF_CHR, 32'h1313_1111);
		rd(`UFC_OFF_ISR, 32'h01);
		rd(`UFC_OFF_FUR, 32'h08);
		apb(1'b0, 8'h28, 32'h0);
		chk("unmapped err", 32'h1, rerr);
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, `UFC_OFF_FCR, {24'h0, i[1:0], 2'(3 - i), 4'h1});
			rd(`UFC_OFF_FUR, up_t[i]);
			rd(`UFC_OFF_FLR, lo_t[3 - i]);
		end
		apb(1'b1, `UFC_OFF_FUR, 32'h1F);
		rd(`UFC_OFF_FUR, up_t[3]);
		apb(1'b1, `UFC_OFF_AFR, 32'h1);
		apb(1'b1, `UFC_OFF_FUR, 32'h20);
		apb(1'b1, `UFC_OFF_FLR, 32'h04);
		rd(`UFC_OFF_FUR, 32'h20);
		rd(`UFC_OFF_FLR, 32'h04);
		apb(1'b1, `UFC_OFF_CHR, 32'h4433_2211);
		apb(1'b1, `UFC_OFF_IER, 32'h80);
		for (int i = 0; i < 3; i++) begin
			slow <= (i == 2);
			apb(1'b1, `UFC_OFF_EFR, {24'h0, ftx_t[i]});
			fill <= 9'h020;
			chk_tx(16'h0, 0);
			fill <= 9'h021;
			chk_tx(stop_t[i], n_t[i]);
			rd(`UFC_OFF_FSR, 32'h10);
			fill <= 9'h010;
			chk_tx(16'h0, 0);
			fill <= 9'h004;
			chk_tx(res_t[i], n_t[i]);
			rd(`UFC_OFF_FSR, 32'h00);
			apb(1'b1, `UFC_OFF_EFR, 32'h0);
		end
		chk("irq", 32'h0, irq);
		for (int i = 0; i < 3; i++) begin
			apb(1'b1, `UFC_OFF_EFR, {24'h0, frx_t[i]});
			rx_seq(stop_t[i], n_t[i]);
			load(8'hA5);
			chk_tx(16'h0, 0);
			rd(`UFC_OFF_FSR, 32'h01);
			rx_seq(res_t[i], n_t[i]);
			chk_tx(16'hA500, 1);
			rd(`UFC_OFF_FSR, 32'h00);
		end
		apb(1'b1, `UFC_OFF_EFR, 32'h88);
		cts_n_in <= 1'b1;
		// pin needs two sync flops before it can gate
		repeat (3) @(posedge pclk);
		load(8'hA5);
		chk_tx(16'h0, 0);
		rd(`UFC_OFF_FSR, 32'h02);
		rd(`UFC_OFF_ISR, 32'h20);
		chk("irq", 32'h1, irq);
		fill <= 9'h021;
		chk_tx(16'h3300, 1);
		rd(`UFC_OFF_MSR, 32'h01);
		rd(`UFC_OFF_ISR, 32'h01);
		chk("irq", 32'h0, irq);
		cts_n_in <= 1'b0;
		chk_tx(16'hA500, 1);
		rd(`UFC_OFF_FSR, 32'h10);
		apb(1'b1, `UFC_OFF_EFR, 32'h0);
		cts_n_in <= 1'b1;
		load(8'h5A);
		chk_tx(16'h5A00, 1);
		end_of_test();
	end
endmodule // ufc_flow_top_test
